// *** trib_pkg.sv ***
// Package for the tributary loopback and alarm monitor.
// Assumes a single 10 MHz system clock and a synchronous active-high reset.
package trib_pkg;
  localparam int NUM_TRIB = 4;
  localparam int CLK_HZ = 10_000_000;
  localparam int SEC_CYCLES = CLK_HZ;
  localparam int ZERO_LIMIT = 192;
  localparam int ZERO_CNT_W = 8;
  localparam int SUB_ZERO_MIN = 3;
  localparam int ONES_LIMIT = 2048;
  localparam int ONES_CNT_W = 12;
  localparam int BINS_PER_DAY = 96;
  localparam int DAYS_KEPT = 7;
  localparam int ES_CNT_W = 10;
  localparam int DAY_CNT_W = 17;
  localparam int FIFO_DEPTH = 8;

  // Remote loop modes are requests carried to the peer; the peer's framer does the loop
  typedef enum logic [2:0] {
    LOOP_NORMAL,
    LOOP_LINK_LOCAL,
    LOOP_LINK_REMOTE,
    LOOP_LINE_LOCAL,
    LOOP_LINE_REMOTE
  } loop_mode_t;

  typedef enum logic {FRAME_ESF, FRAME_D4} t1_framing_t;
  typedef enum logic {CODE_B8ZS, CODE_AMI} t1_code_t;

  // One received line bit in dual-rail form
  typedef struct packed {
    logic pos;
    logic neg;
  } rail_t;

  typedef struct packed {
    logic no_signal;
    logic all_ones;
    logic remote_failure;
    logic sync_loss;
    logic bipolar_violation;
    logic out_of_frame;
    logic crc_frame_loss;
    logic code_violation;
  } alarm_t;

  localparam alarm_t ALARM_NONE = '0;
endpackage

// *** trib_fifo.sv ***
// Small flip-flop FIFO with valid/ready handshakes on both sides.
// Assumes both sides run on the same clock as the caller.
`timescale 1ns/10ps
module trib_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [WIDTH-1:0] in_data, // Write data
  input wire logic in_valid, // Write request
  output logic in_ready, // Space available
  output logic [WIDTH-1:0] out_data, // Read data
  output logic out_valid, // Data available
  input wire logic out_ready // Reader accepts
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

// *** trib_monitor.sv ***
// Four-tributary loopback selector, line alarm monitor and error-second history.
// Assumes line bits arrive as dual-rail pin levels with a bit strobe pin; framer
// status pins (frame sync, CRC-4 sync, remote failure) come from an external framer.
`timescale 1ns/10ps
module trib_monitor
  import trib_pkg::*;
#(
  parameter int NT = NUM_TRIB,
  parameter int SEC_LEN = SEC_CYCLES,
  parameter int BINS = BINS_PER_DAY,
  parameter int DAYS = DAYS_KEPT
) (
  input wire logic clk_sys, // 10 MHz system clock
  input wire logic rst, // Synchronous reset, active high
  input wire loop_mode_t loop_cfg [NT], // Requested loop mode per tributary
  input wire t1_framing_t framing_cfg [NT], // T1 framing per tributary
  input wire t1_code_t code_cfg [NT], // T1 line code per tributary
  input wire logic [NT-1:0] cfg_load, // Load the three settings above
  input wire logic [NT-1:0] is_e1, // Tributary is E1
  input wire logic report_en_set, // Pulse: set local reporting state
  input wire logic report_en_val, // Value for reporting state
  input wire rail_t line_rx [NT], // Line receive dual-rail pins
  input wire logic [NT-1:0] line_strobe, // Line bit strobe pins
  input wire logic [NT-1:0] framer_sync, // Framer frame-aligned pins
  input wire logic [NT-1:0] framer_crc_sync, // Framer CRC-4 aligned pins
  input wire logic [NT-1:0] framer_rmt, // Equipment remote alarm pins
  input wire rail_t radio_rx [NT], // Bits received from radio
  input wire logic [NT-1:0] radio_rx_valid, // Radio bit valid
  input wire alarm_t peer_alarm [NT], // Alarms reported by the peer
  output rail_t line_tx [NT], // Bits toward line equipment
  output rail_t radio_tx [NT], // Bits toward radio
  output logic [NT-1:0] radio_tx_valid, // Radio transmit valid
  input wire logic [NT-1:0] radio_tx_ready, // Radio accepts transmit bit
  output logic [NT-1:0] line_rx_overflow, // Sticky: FIFO input bit dropped (radio bit in link loop)
  output loop_mode_t loop_state [NT], // Active local loop mode
  output loop_mode_t peer_loop_req [NT], // Loop request sent to peer
  output t1_framing_t framing_state [NT], // Framing in use, also sent to peer
  output t1_code_t code_state [NT], // Line code in use
  output alarm_t local_alarm [NT], // Reported local alarms
  output alarm_t remote_alarm [NT], // Reported peer alarms
  output alarm_t alarm_to_peer [NT], // Unmasked local alarms for the peer
  output logic [NT-1:0] alarm_led, // Status indicator
  output logic report_en, // Local reporting state
  output logic [NT-1:0] es_pulse, // One-cycle: second was errored
  output logic [NT-1:0] ses_pulse, // One-cycle: second was severely errored
  output logic [ES_CNT_W-1:0] bin_es [NT][BINS], // 15-minute ES bins, 0 is newest
  output logic [ES_CNT_W-1:0] bin_ses [NT][BINS], // 15-minute SES bins
  output logic [DAY_CNT_W-1:0] day_es [NT][DAYS], // Daily ES totals, 0 is newest
  output logic [DAY_CNT_W-1:0] day_ses [NT][DAYS] // Daily SES totals
);
  localparam int SEC_W = $clog2(SEC_LEN + 1);
  localparam int BIN_SECS = 900;
  localparam int BSEC_W = 10;
  localparam int BIN_W = $clog2(BINS + 1);

  // Shared one-second and bin timebase
  logic [SEC_W-1:0] sec_cnt;
  logic [BSEC_W-1:0] bin_sec;
  logic [BIN_W-1:0] bin_idx;
  logic sec_tick;
  logic bin_tick;
  logic day_tick;
  wire sec_end = (sec_cnt == SEC_W'(SEC_LEN - 1));
  wire bin_end = sec_end && (bin_sec == BSEC_W'(BIN_SECS - 1));
  wire day_end = bin_end && (bin_idx == BIN_W'(BINS - 1));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sec_cnt <= '0;
      bin_sec <= '0;
      bin_idx <= '0;
      sec_tick <= 1'b0;
      bin_tick <= 1'b0;
      day_tick <= 1'b0;
    end else begin
      sec_cnt <= sec_end ? '0 : sec_cnt + 1'b1;
      if (sec_end) begin
        bin_sec <= (bin_sec == BSEC_W'(BIN_SECS - 1)) ? '0 : bin_sec + 1'b1;
      end
      if (bin_end) begin
        bin_idx <= day_end ? '0 : bin_idx + 1'b1;
      end
      sec_tick <= sec_end;
      bin_tick <= bin_end;
      day_tick <= day_end;
    end
  end

  // Reporting state is held per unit; the peer keeps its own
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      report_en <= 1'b1;
    end else if (report_en_set) begin
      report_en <= report_en_val;
    end
  end

  genvar t;
  generate
    for (t = 0; t < NT; t++) begin : g_trib
      // Pin synchronisers, two stages before any use
      rail_t rx_s1, rx_s2;
      logic [2:0] stb_s1, stb_s2;
      logic stb_d;
      always_ff @(posedge clk_sys) begin
        rx_s1 <= line_rx[t];
        rx_s2 <= rx_s1;
        stb_s1 <= {framer_rmt[t], framer_crc_sync[t], framer_sync[t]};
        stb_s2 <= stb_s1;
      end
      logic lstb_s1, lstb_s2;
      always_ff @(posedge clk_sys) begin
        lstb_s1 <= line_strobe[t];
        lstb_s2 <= lstb_s1;
        stb_d <= lstb_s2;
      end
      wire bit_ev = lstb_s2 && !stb_d;
      wire mark = rx_s2.pos || rx_s2.neg;

      // Line bit monitors
      logic [ZERO_CNT_W-1:0] zero_run;
      logic [ONES_CNT_W-1:0] ones_run;
      logic last_pol;
      logic bpv_ev;
      wire same_pol = mark && (rx_s2.pos == last_pol);
      // B8ZS/HDB3 substitutions carry deliberate violations; AMI has none
      wire sub_ok = is_e1[t] || (code_state[t] == CODE_B8ZS);
      wire zero_run_long = (zero_run >= ZERO_CNT_W'(SUB_ZERO_MIN));
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          zero_run <= '0;
          ones_run <= '0;
          last_pol <= 1'b0;
          bpv_ev <= 1'b0;
        end else begin
          bpv_ev <= bit_ev && same_pol && !(sub_ok && zero_run_long);
          if (bit_ev) begin
            if (mark) begin
              zero_run <= '0;
              last_pol <= rx_s2.pos;
              if (ones_run != ONES_CNT_W'(ONES_LIMIT)) begin
                ones_run <= ones_run + 1'b1;
              end
            end else begin
              ones_run <= '0;
              if (zero_run != ZERO_CNT_W'(ZERO_LIMIT)) begin
                zero_run <= zero_run + 1'b1;
              end
            end
          end
        end
      end

      wire alarm_t raw;
      assign raw.no_signal = (zero_run == ZERO_CNT_W'(ZERO_LIMIT));
      assign raw.all_ones = (ones_run == ONES_CNT_W'(ONES_LIMIT)) && !stb_s2[0];
      assign raw.remote_failure = stb_s2[2];
      assign raw.sync_loss = !is_e1[t] && !stb_s2[0];
      assign raw.bipolar_violation = !is_e1[t] && bpv_ev;
      assign raw.out_of_frame = is_e1[t] && !stb_s2[0];
      assign raw.crc_frame_loss = is_e1[t] && !stb_s2[1];
      assign raw.code_violation = is_e1[t] && bpv_ev;

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          local_alarm[t] <= ALARM_NONE;
          remote_alarm[t] <= ALARM_NONE;
          alarm_to_peer[t] <= ALARM_NONE;
          alarm_led[t] <= 1'b0;
        end else begin
          alarm_to_peer[t] <= raw;
          local_alarm[t] <= report_en ? raw : ALARM_NONE;
          remote_alarm[t] <= report_en ? peer_alarm[t] : ALARM_NONE;
          alarm_led[t] <= report_en && (raw != ALARM_NONE);
        end
      end

      // Settings: one exclusive loop mode per tributary
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          loop_state[t] <= LOOP_NORMAL;
          framing_state[t] <= FRAME_ESF;
          code_state[t] <= CODE_B8ZS;
        end else if (cfg_load[t]) begin
          loop_state[t] <= loop_cfg[t];
          framing_state[t] <= framing_cfg[t];
          code_state[t] <= code_cfg[t];
        end
      end
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          peer_loop_req[t] <= LOOP_NORMAL;
        end else begin
          peer_loop_req[t] <= loop_state[t];
        end
      end

      // Line to radio path goes through the FIFO; radio back-pressure fills it
      wire line_loop = (loop_state[t] == LOOP_LINE_LOCAL);
      wire link_loop = (loop_state[t] == LOOP_LINK_LOCAL);
      wire rail_t fifo_in = link_loop ? radio_rx[t] : rx_s2;
      wire fifo_in_valid = link_loop ? radio_rx_valid[t] : (bit_ev && !line_loop);
      logic fifo_in_ready;
      rail_t fifo_out;
      logic fifo_out_valid;
      trib_fifo #(.WIDTH($bits(rail_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_data(fifo_in),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_out_valid),
        .out_ready(radio_tx_ready[t] || !radio_tx_valid[t])
      );
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          radio_tx[t] <= '0;
          radio_tx_valid[t] <= 1'b0;
          line_rx_overflow[t] <= 1'b0;
        end else begin
          if (radio_tx_ready[t] || !radio_tx_valid[t]) begin
            radio_tx[t] <= fifo_out;
            radio_tx_valid[t] <= fifo_out_valid;
          end
          if (fifo_in_valid && !fifo_in_ready) begin
            line_rx_overflow[t] <= 1'b1;
          end
        end
      end

      // Radio to line path, or line looped straight back
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          line_tx[t] <= '0;
        end else if (line_loop) begin
          if (bit_ev) begin
            line_tx[t] <= rx_s2;
          end
        end else if (link_loop) begin
          line_tx[t] <= '0;
        end else if (radio_rx_valid[t]) begin
          line_tx[t] <= radio_rx[t];
        end
      end

      // Error seconds: a flag per second, counted once at the tick
      logic es_flag, ses_flag;
      wire es_ev = is_e1[t]
        ? (raw.no_signal || raw.out_of_frame || raw.code_violation
           || raw.crc_frame_loss)
        : (raw.no_signal || raw.all_ones || raw.sync_loss || raw.bipolar_violation);
      wire ses_ev = is_e1[t] ? (raw.no_signal || raw.out_of_frame)
        : (raw.no_signal || raw.all_ones || raw.sync_loss);
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          es_flag <= 1'b0;
          ses_flag <= 1'b0;
          es_pulse[t] <= 1'b0;
          ses_pulse[t] <= 1'b0;
        end else begin
          // An event on the closing cycle belongs to the closing second only
          es_flag <= sec_end ? 1'b0 : (es_flag || es_ev);
          ses_flag <= sec_end ? 1'b0 : (ses_flag || ses_ev);
          es_pulse[t] <= sec_end && (es_flag || es_ev);
          ses_pulse[t] <= sec_end && (ses_flag || ses_ev);
        end
      end

      // Bin 0 accumulates; a new interval shifts every bin down one slot
      logic [DAY_CNT_W-1:0] day_acc_es, day_acc_ses;
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          for (int b = 0; b < BINS; b++) begin
            bin_es[t][b] <= '0;
            bin_ses[t][b] <= '0;
          end
          for (int d = 0; d < DAYS; d++) begin
            day_es[t][d] <= '0;
            day_ses[t][d] <= '0;
          end
          day_acc_es <= '0;
          day_acc_ses <= '0;
        end else begin
          if (bin_tick) begin
            for (int b = BINS - 1; b > 0; b--) begin
              bin_es[t][b] <= bin_es[t][b-1];
              bin_ses[t][b] <= bin_ses[t][b-1];
            end
            // The last second's pulse arrives with the shift; fold it into the closed bin
            bin_es[t][1] <= bin_es[t][0] + ES_CNT_W'(es_pulse[t]);
            bin_ses[t][1] <= bin_ses[t][0] + ES_CNT_W'(ses_pulse[t]);
            bin_es[t][0] <= '0;
            bin_ses[t][0] <= '0;
          end else begin
            bin_es[t][0] <= bin_es[t][0] + ES_CNT_W'(es_pulse[t]);
            bin_ses[t][0] <= bin_ses[t][0] + ES_CNT_W'(ses_pulse[t]);
          end
          if (day_tick) begin
            for (int d = DAYS - 1; d > 0; d--) begin
              day_es[t][d] <= day_es[t][d-1];
              day_ses[t][d] <= day_ses[t][d-1];
            end
            day_es[t][0] <= day_acc_es + DAY_CNT_W'(es_pulse[t]);
            day_ses[t][0] <= day_acc_ses + DAY_CNT_W'(ses_pulse[t]);
            day_acc_es <= '0;
            day_acc_ses <= '0;
          end else begin
            day_acc_es <= day_acc_es + DAY_CNT_W'(es_pulse[t]);
            day_acc_ses <= day_acc_ses + DAY_CNT_W'(ses_pulse[t]);
          end
        end
      end
    end
  endgenerate

  logic unused_tick;
  assign unused_tick = sec_tick;
endmodule

// *** trib_monitor_properties.sv ***
// Checker for the tributary monitor: settings, reporting mask and second pulses.
// Assumes it is bound to trib_monitor and sees only that module's ports.
`timescale 1ns/10ps
module trib_monitor_properties
  import trib_pkg::*;
#(
  parameter int NT = NUM_TRIB
) (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire loop_mode_t loop_cfg [NT], // Loop setting
  input wire t1_framing_t framing_cfg [NT], // Framing setting
  input wire t1_code_t code_cfg [NT], // Code setting
  input wire logic [NT-1:0] cfg_load, // Load strobe
  input wire logic report_en_set, // Report set pulse
  input wire logic report_en_val, // Report value
  input wire alarm_t peer_alarm [NT], // Peer alarms in
  input wire loop_mode_t loop_state [NT], // Loop in use
  input wire loop_mode_t peer_loop_req [NT], // Request to peer
  input wire t1_framing_t framing_state [NT], // Framing in use
  input wire t1_code_t code_state [NT], // Code in use
  input wire alarm_t local_alarm [NT], // Local alarms
  input wire alarm_t remote_alarm [NT], // Peer alarms shown
  input wire logic [NT-1:0] alarm_led, // Indicator
  input wire logic report_en, // Reporting state
  input wire logic [NT-1:0] es_pulse, // Errored second
  input wire logic [NT-1:0] ses_pulse // Severely errored second
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_LOOP_LOAD: assert property (cfg_load[0] |=> loop_state[0] == $past(loop_cfg[0]))
    else $error("loop state not taken from setting");
  // A second load right behind would legally overwrite the request
  AST_PEER_REQ: assert property ((cfg_load[0] && loop_cfg[0] inside {LOOP_LINK_REMOTE,
    LOOP_LINE_REMOTE} ##1 !cfg_load[0]) |=> peer_loop_req[0] == $past(loop_cfg[0], 2))
    else $error("remote loop not requested from peer");
  AST_FRAME_LOAD: assert property (cfg_load[0] |=> framing_state[0] == $past(framing_cfg[0])
    && code_state[0] == $past(code_cfg[0]))
    else $error("framing or code not taken");
  AST_REPORT: assert property (report_en_set |=> report_en == $past(report_en_val))
    else $error("reporting state not taken");
  AST_MASK: assert property (!report_en |=> local_alarm[0] == ALARM_NONE
    && remote_alarm[0] == ALARM_NONE && !alarm_led[0])
    else $error("alarm shown while reporting disabled");
  AST_LED: assert property (report_en |=> alarm_led[0] == (local_alarm[0] != ALARM_NONE))
    else $error("indicator disagrees with alarms");
  AST_REMOTE: assert property (report_en |=> remote_alarm[0] == $past(peer_alarm[0]))
    else $error("peer alarm not presented");
  AST_ES_GAP: assert property (es_pulse[0] |=> !es_pulse[0] [*8])
    else $error("errored second marked twice");
  AST_SES_ES: assert property (ses_pulse[0] |-> es_pulse[0])
    else $error("severe second without errored second");
endmodule

bind trib_monitor trib_monitor_properties #(.NT(NT)) u_props (
  .clk_sys(clk_sys), .rst(rst), .loop_cfg(loop_cfg), .framing_cfg(framing_cfg),
  .code_cfg(code_cfg), .cfg_load(cfg_load), .report_en_set(report_en_set),
  .report_en_val(report_en_val), .peer_alarm(peer_alarm), .loop_state(loop_state),
  .peer_loop_req(peer_loop_req), .framing_state(framing_state), .code_state(code_state),
  .local_alarm(local_alarm), .remote_alarm(remote_alarm), .alarm_led(alarm_led),
  .report_en(report_en), .es_pulse(es_pulse), .ses_pulse(ses_pulse)
);

// *** trib_partner.sv ***
// Model of the line equipment and the radio peer for the tributary monitor.
// Assumes the bench calls send_bit from the falling clock edge.
`timescale 1ns/10ps
module trib_partner
  import trib_pkg::*;
#(
  parameter int NT = NUM_TRIB
) (
  input wire logic clk_sys, // Clock
  input wire logic [NT-1:0] stall, // Hold off the radio side
  input wire rail_t radio_tx [NT], // Bits from the device
  input wire logic [NT-1:0] radio_tx_valid, // Bit offered
  output logic [NT-1:0] radio_tx_ready, // Bit accepted
  output rail_t line_rx [NT], // Line rail pins
  output logic [NT-1:0] line_strobe // Line bit strobe
);
  rail_t got [NT][$];

  initial begin
    radio_tx_ready = '0;
    line_strobe = '0;
    for (int i = 0; i < NT; i++) line_rx[i] = '0;
  end

  always @(negedge clk_sys) radio_tx_ready <= ~stall;

  always @(posedge clk_sys) begin
    for (int i = 0; i < NT; i++) begin
      if (radio_tx_valid[i] && radio_tx_ready[i]) got[i].push_back(radio_tx[i]);
    end
  end

  // Rails are only valid while the strobe is high; afterwards they show junk
  task automatic send_bit(input int t, input rail_t b);
    line_rx[t] = b;
    line_strobe[t] = 1'b1;
    repeat (4) @(negedge clk_sys);
    line_strobe[t] = 1'b0;
    line_rx[t] = ~b;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the four-tributary loopback and alarm monitor.
// Assumes the package, FIFO, monitor, partner model and checker are compiled first.
`timescale 1ns/10ps
module testbench;
  import trib_pkg::*;
  localparam int NT = NUM_TRIB;
  localparam int SEC_LEN = 20;
  localparam int NB = 4;
  localparam int ND = 2;
  localparam int BIN_CYC = 900 * SEC_LEN;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  loop_mode_t loop_cfg [NT];
  loop_mode_t loop_state [NT];
  loop_mode_t peer_loop_req [NT];
  t1_framing_t framing_cfg [NT];
  t1_framing_t framing_state [NT];
  t1_code_t code_cfg [NT];
  t1_code_t code_state [NT];
  rail_t line_rx [NT];
  rail_t radio_rx [NT];
  rail_t line_tx [NT];
  rail_t radio_tx [NT];
  alarm_t peer_alarm [NT];
  alarm_t local_alarm [NT];
  alarm_t remote_alarm [NT];
  logic [NT-1:0] cfg_load, is_e1, line_strobe, framer_sync, framer_crc_sync, framer_rmt;
  logic [NT-1:0] radio_rx_valid, radio_tx_valid, radio_tx_ready, line_rx_overflow;
  logic [NT-1:0] alarm_led, es_pulse, ses_pulse, stall;
  logic report_en_set, report_en_val, report_en, f;
  int n_mismatch = 0;
  int n_compared = 0;
  int e, s;
  int n_cyc = 0;
  int n_es3 = 0;
  alarm_t alarm_to_peer [NT];
  logic [ES_CNT_W-1:0] bin_es [NT][NB];
  logic [ES_CNT_W-1:0] bin_ses [NT][NB];
  logic [DAY_CNT_W-1:0] day_es [NT][ND];

  always #50 clk_sys = ~clk_sys;

  // A short second keeps the error-second pulse checks within a few hundred cycles and one 15-minute bin at 18000 cycles
  trib_monitor #(.SEC_LEN(SEC_LEN), .BINS(NB), .DAYS(ND)) dut (
    .clk_sys(clk_sys), .rst(rst), .loop_cfg(loop_cfg), .framing_cfg(framing_cfg),
    .code_cfg(code_cfg), .cfg_load(cfg_load), .is_e1(is_e1), .report_en_set(report_en_set),
    .report_en_val(report_en_val), .line_rx(line_rx), .line_strobe(line_strobe),
    .framer_sync(framer_sync), .framer_crc_sync(framer_crc_sync), .framer_rmt(framer_rmt),
    .radio_rx(radio_rx), .radio_rx_valid(radio_rx_valid), .peer_alarm(peer_alarm),
    .line_tx(line_tx), .radio_tx(radio_tx), .radio_tx_valid(radio_tx_valid),
    .radio_tx_ready(radio_tx_ready), .line_rx_overflow(line_rx_overflow),
    .loop_state(loop_state), .peer_loop_req(peer_loop_req), .framing_state(framing_state),
    .code_state(code_state), .local_alarm(local_alarm), .remote_alarm(remote_alarm),
    .alarm_to_peer(alarm_to_peer), .alarm_led(alarm_led), .report_en(report_en),
    .es_pulse(es_pulse), .ses_pulse(ses_pulse), .bin_es(bin_es), .bin_ses(bin_ses),
    .day_es(day_es), .day_ses()
  );

  // Own tally of trib 3 errored seconds over the first 15-minute bin
  always @(posedge clk_sys) begin
    if (rst) begin
      n_cyc = 0;
      n_es3 = 0;
    end else begin
      n_cyc++;
      if (es_pulse[3] === 1'b1 && n_cyc <= BIN_CYC + 1) n_es3++;
    end
  end

  trib_partner p (
    .clk_sys(clk_sys), .stall(stall), .radio_tx(radio_tx), .radio_tx_valid(radio_tx_valid),
    .radio_tx_ready(radio_tx_ready), .line_rx(line_rx), .line_strobe(line_strobe)
  );

  task automatic check(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic load(input int t, input loop_mode_t m, input t1_framing_t fr, input t1_code_t cd);
    loop_cfg[t] = m;
    framing_cfg[t] = fr;
    code_cfg[t] = cd;
    cfg_load[t] = 1'b1;
    @(negedge clk_sys);
    cfg_load[t] = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic radio_bit(input int t, input rail_t b);
    radio_rx[t] = b;
    radio_rx_valid[t] = 1'b1;
    @(negedge clk_sys);
    radio_rx_valid[t] = 1'b0;
    radio_rx[t] = ~b;
  endtask

  task automatic expect_radio(input int t, input rail_t x);
    repeat (8) @(negedge clk_sys);
    check(p.got[t].size(), 1);
    if (p.got[t].size() > 0) check(p.got[t].pop_front(), x);
  endtask

  // One-cycle alarms are caught by watching every cycle of a bounded window
  task automatic seen(input int t, input int b, input int n, output logic hit);
    hit = 1'b0;
    repeat (n) begin
      @(negedge clk_sys);
      if (local_alarm[t][b] === 1'b1) hit = 1'b1;
    end
  endtask

  task automatic pulses(input int t, input int n, output int ne, output int ns);
    ne = 0;
    ns = 0;
    repeat (n) begin
      @(negedge clk_sys);
      if (es_pulse[t] === 1'b1) ne++;
      if (ses_pulse[t] === 1'b1) ns++;
    end
  endtask

  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    for (int i = 0; i < NT; i++) begin
      loop_cfg[i] = LOOP_NORMAL;
      framing_cfg[i] = FRAME_ESF;
      code_cfg[i] = CODE_B8ZS;
      radio_rx[i] = '0;
      peer_alarm[i] = ALARM_NONE;
    end
    {cfg_load, is_e1, framer_rmt, radio_rx_valid, stall} = '0;
    framer_sync = '1;
    framer_crc_sync = '1;
    report_en_set = 1'b0;
    report_en_val = 1'b1;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    for (int t = 0; t < NT; t++) begin
      check(loop_state[t], LOOP_NORMAL);
      check(framing_state[t], FRAME_ESF);
      check(code_state[t], CODE_B8ZS);
    end
    check(report_en, 1'b1);
    $display("test defaults done");
    for (int t = 0; t < NT; t++) begin
      for (int m = 0; m < 5; m++) begin
        load(t, loop_mode_t'(m), FRAME_D4, CODE_AMI);
        check(loop_state[t], m);
        check(framing_state[t], FRAME_D4);
        check(code_state[t], CODE_AMI);
      end
    end
    $display("test settings done");
    load(0, LOOP_NORMAL, FRAME_ESF, CODE_AMI);
    p.got[0].delete();
    p.send_bit(0, 2'b10);
    expect_radio(0, 2'b10);
    radio_bit(0, 2'b01);
    check(line_tx[0], 2'b01);
    load(0, LOOP_LINK_LOCAL, FRAME_ESF, CODE_AMI);
    radio_bit(0, 2'b10);
    expect_radio(0, 2'b10);
    check(line_tx[0], 2'b00);
    load(0, LOOP_LINE_LOCAL, FRAME_ESF, CODE_AMI);
    p.send_bit(0, 2'b01);
    check(line_tx[0], 2'b01);
    check(p.got[0].size(), 0);
    $display("test paths done");
    load(0, LOOP_NORMAL, FRAME_ESF, CODE_AMI);
    p.send_bit(0, 2'b10);
    fork
      p.send_bit(0, 2'b10);
      seen(0, 3, 12, f);
    join
    check(f, 1'b1);
    is_e1[1] = 1'b1;
    p.send_bit(1, 2'b10);
    fork
      p.send_bit(1, 2'b10);
      seen(1, 0, 12, f);
      pulses(1, 50, e, s);
    join
    check(f, 1'b1);
    check(e, 1);
    check(s, 0);
    $display("test violations done");
    framer_sync[1] = 1'b0;
    framer_crc_sync[1] = 1'b0;
    seen(1, 2, 10, f);
    check(f, 1'b1);
    seen(1, 1, 10, f);
    check(f, 1'b1);
    pulses(1, 100, e, s);
    check(e, 5);
    check(s, 5);
    framer_sync[1] = 1'b1;
    framer_crc_sync[1] = 1'b1;
    framer_sync[0] = 1'b0;
    framer_rmt[0] = 1'b1;
    seen(0, 4, 10, f);
    check(f, 1'b1);
    seen(0, 5, 10, f);
    check(f, 1'b1);
    peer_alarm[2] = 8'h20;
    repeat (3) @(negedge clk_sys);
    check(remote_alarm[2], 8'h20);
    report_en_set = 1'b1;
    report_en_val = 1'b0;
    @(negedge clk_sys);
    report_en_set = 1'b0;
    repeat (3) @(negedge clk_sys);
    check(report_en, 1'b0);
    check(local_alarm[0], ALARM_NONE);
    check(remote_alarm[2], ALARM_NONE);
    check(alarm_led[0], 1'b0);
    check(alarm_to_peer[0], 8'h30);
    report_en_set = 1'b1;
    report_en_val = 1'b1;
    @(negedge clk_sys);
    report_en_set = 1'b0;
    repeat (3) @(negedge clk_sys);
    check(alarm_led[0], 1'b1);
    framer_sync[0] = 1'b1;
    framer_rmt[0] = 1'b0;
    $display("test alarms done");
    repeat (191) p.send_bit(3, 2'b00);
    check(local_alarm[3][7], 1'b0);
    fork
      p.send_bit(3, 2'b00);
      seen(3, 7, 12, f);
    join
    check(f, 1'b1);
    framer_sync[2] = 1'b0;
    for (int i = 0; i < 2048; i++) p.send_bit(2, i[0] ? 2'b01 : 2'b10);
    check(local_alarm[2][6], 1'b1);
    $display("test line alarms done");
    stall[0] = 1'b1;
    repeat (2) @(negedge clk_sys);
    p.got[0].delete();
    for (int i = 0; i < 11; i++) p.send_bit(0, i[0] ? 2'b01 : 2'b10);
    check(line_rx_overflow[0], 1'b1);
    stall[0] = 1'b0;
    repeat (30) @(negedge clk_sys);
    check(p.got[0].size() >= FIFO_DEPTH, 1'b1);
    $display("test buffer done");
    for (int i = 0; i < 20000 && n_cyc <= BIN_CYC + 1; i++) @(negedge clk_sys);
    check(n_cyc > BIN_CYC + 1, 1'b1);
    check(n_es3 > 0, 1'b1);
    check(bin_es[3][1], n_es3);
    check(bin_ses[3][1], n_es3);
    check(day_es[3][0], 0);
    $display("test history done");
    summarize();
  end
endmodule
